/* inc/csc_pkg.sv */
// constants and types of the clock source and standby control block
// Functional notes
// (R1) Standby entered only when enter directly follows arm
// (R2) Software disables interrupts before arm and enter
// (R3) First oscillator type selection wins, later ignored
// (R4) Type selection neither starts oscillator nor switches
// (R5) No type selected: system clock from ring only
// (R6) Non-oscillating source never becomes system clock
// (R7) Active system clock source cannot be stopped
// (R8) Main clock input forced high in standby or stopped
// (R9) Forced high from reset until selected and enabled
// (R10) External clock: select ceramic, then enable main
// (R11) Software selects oscillator type in its init routine
// (R12) Main stop bit: zero runs, one stops main
// (R13) Source bit: zero main, one ring oscillator
// (R14) Divide bits 00/01/10/11 give 1/2/4/8; reset ones
// (R15) Ring stop bit: zero runs, one stops; resets zero
// (R16) Refused clock writes leave configuration unchanged
`default_nettype none
package csc_pkg;
   // register byte offsets
   localparam logic [3:0] OFF_CMD  = 4'h0;
   localparam logic [3:0] OFF_MR   = 4'h4;
   localparam logic [3:0] OFF_RG   = 4'h8;
   localparam logic [3:0] OFF_STAT = 4'hC;
   // clock control field positions and reset values
   localparam int MR_SRC = 0;
   localparam int MR_STOP = 1;
   localparam int MR_DIV_LO = 2;
   localparam logic [3:0] MR_RST = 4'hF;
   localparam logic       RG_RST = 1'b0;
   // instruction codes written to the command register
   localparam logic [2:0] CMD_CER = 3'h1;
   localparam logic [2:0] CMD_RC = 3'h2;
   localparam logic [2:0] CMD_XTL = 3'h3;
   localparam logic [2:0] CMD_ARM = 3'h4;
   localparam logic [2:0] CMD_ENTER = 3'h5;
   localparam logic [2:0] CMD_IDIS = 3'h6;
   // htrans nonseq bit
   localparam int HT_ACTIVE = 1;
   typedef enum logic [1:0] {
      OSC_NONE = 2'h0,
      OSC_CER  = 2'h1,
      OSC_RC   = 2'h2,
      OSC_XTL  = 2'h3
   } csc_osc_e;
   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_ARMED = 3'b010,
      ST_STBY  = 3'b100
   } csc_state_e;
endpackage : csc_pkg
`default_nettype wire

/* hdl/csc_sync.sv */
// two-stage synchroniser for pin inputs
`default_nettype none
module csc_sync #(
   parameter int W = 2
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // asynchronous in, synchronous out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : csc_sync
`default_nettype wire

/* hdl/csc_div.sv */
// system clock divider producing a one-cycle tick every 1, 2, 4 or 8 cycles
`default_nettype none
module csc_div #(
   parameter int CW = 3
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control
   input  wire logic       run,
   input  wire logic [1:0] sel,
   // tick out
   output logic            tick
);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] mask;
   logic          tick_d;

   always_comb begin
      mask   = CW'((1 << sel) - 1);
      tick_d = 1'b0;
      cnt_d  = '0;
      if (run) begin
         if (cnt_q >= mask) begin  // see (R14)
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end
endmodule : csc_div
`default_nettype wire

/* hdl/csc_top.sv */
// clock source selection and standby entry control, AHB-Lite slave
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`default_nettype none
module csc_top (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // pins
   input  wire logic        main_clock_input_pin,
   input  wire logic        wake_req,
   // clock control outputs
   output logic             main_osc_clock,
   output logic             main_clk_force_high,
   output logic             main_osc_en,
   output logic [1:0]       main_osc_type,
   output logic             ring_osc_en,
   output logic             sysclk_sel_main,
   output logic [1:0]       sysclk_div,
   output logic             sysclk_tick,
   output logic             standby
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] pins_s;
   logic       pin_s;
   logic       wake_s;

   csc_sync #(.W(2)) u_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     ({wake_req, main_clock_input_pin}),
      .q     (pins_s)
   );
   assign pin_s  = pins_s[0];
   assign wake_s = pins_s[1];

   ////////////////////////////////////////////////////////////////////////
   // bus address phase capture
   logic       dv_q, dv_d;
   logic       wr_q, wr_d;
   logic [3:0] addr_q, addr_d;
   logic [31:0] rdata_d;
   logic        take;

   // state of the clock control
   logic [3:0]            mr_q, mr_d;
   logic                  rg_q, rg_d;
   logic                  tset_q, tset_d;
   csc_pkg::csc_osc_e     type_q, type_d;
   csc_pkg::csc_state_e   st_q, st_d;

   assign take = hsel && hready && htrans[csc_pkg::HT_ACTIVE];

   always_comb begin
      dv_d   = take;
      wr_d   = take && hwrite;
      addr_d = {haddr[3:2], 2'h0};
      rdata_d = hrdata;
      if (take && !hwrite) begin
         unique case (addr_d)
            csc_pkg::OFF_MR:   rdata_d = {28'h0, mr_q};
            csc_pkg::OFF_RG:   rdata_d = {31'h0, rg_q};
            csc_pkg::OFF_STAT: rdata_d = {25'h0, st_q, type_q,
                                          tset_q, main_osc_en};
            default:           rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dv_q      <= 1'b0;
         wr_q      <= 1'b0;
         addr_q    <= 4'h0;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dv_q      <= dv_d;
         wr_q      <= wr_d;
         addr_q    <= addr_d;
         hrdata    <= rdata_d;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction decode and write checks
   logic [2:0] cmd;
   logic       is_cmd, is_sel, mr_wr, rg_wr;
   logic       mr_ok, rg_ok;
   logic [3:0] mr_new;

   assign cmd    = hwdata[2:0];
   assign is_cmd = dv_q && wr_q && (addr_q == csc_pkg::OFF_CMD);
   assign is_sel = is_cmd && (cmd == csc_pkg::CMD_CER ||
                   cmd == csc_pkg::CMD_RC || cmd == csc_pkg::CMD_XTL);
   assign mr_wr  = dv_q && wr_q && (addr_q == csc_pkg::OFF_MR);
   assign rg_wr  = dv_q && wr_q && (addr_q == csc_pkg::OFF_RG);
   assign mr_new = hwdata[3:0];

   // main may only be picked once it already oscillates
   always_comb begin
      if (mr_new[csc_pkg::MR_SRC]) begin
         // no type yet: stop bit stays set, so a selection never starts main
         mr_ok = !rg_q  // see (R6)
            && !(mr_new[csc_pkg::MR_STOP]
                 && !mr_q[csc_pkg::MR_SRC])  // see (R7)
            && (tset_q || mr_new[csc_pkg::MR_STOP]);  // see (R4) (R5)
      end else begin
         mr_ok = tset_q && !mr_q[csc_pkg::MR_STOP]  // see (R5) (R6)
            && !mr_new[csc_pkg::MR_STOP];  // see (R7)
      end
      rg_ok = !(hwdata[0] && mr_q[csc_pkg::MR_SRC]);  // see (R7)
   end

   ////////////////////////////////////////////////////////////////////////
   // clock configuration and standby sequence
   always_comb begin
      mr_d   = mr_q;
      rg_d   = rg_q;
      tset_d = tset_q;
      type_d = type_q;
      st_d   = st_q;
      // a refused write keeps the whole old configuration
      if (mr_wr && mr_ok) begin
         mr_d = mr_new;  // see (R12) (R13) (R14) (R16)
      end
      if (rg_wr && rg_ok) begin
         rg_d = hwdata[0];  // see (R15) (R16)
      end
      // only records the type, no start and no switch
      if (is_sel && !tset_q) begin
         tset_d = 1'b1;  // see (R3) (R4)
         type_d = csc_pkg::csc_osc_e'(cmd[1:0]);
      end
      unique case (st_q)
         csc_pkg::ST_RUN: begin
            if (is_cmd && cmd == csc_pkg::CMD_ARM) begin
               st_d = csc_pkg::ST_ARMED;
            end
         end
         csc_pkg::ST_ARMED: begin
            // any other instruction in between breaks the arming
            if (dv_q) begin
               if (is_cmd && cmd == csc_pkg::CMD_ENTER) begin
                  st_d = csc_pkg::ST_STBY;  // see (R1)
                  mr_d = csc_pkg::MR_RST;
                  rg_d = csc_pkg::RG_RST;
               end else if (is_cmd && cmd == csc_pkg::CMD_ARM) begin
                  st_d = csc_pkg::ST_ARMED;
               end else begin
                  st_d = csc_pkg::ST_RUN;  // see (R1)
               end
            end
         end
         csc_pkg::ST_STBY: begin
            // cpu halted: bus writes have no effect here
            mr_d = mr_q;
            rg_d = rg_q;
            tset_d = tset_q;
            type_d = type_q;
            if (wake_s) begin
               st_d = csc_pkg::ST_RUN;
            end
         end
         default: st_d = csc_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mr_q   <= csc_pkg::MR_RST;  // see (R14)
         rg_q   <= csc_pkg::RG_RST;  // see (R15)
         tset_q <= 1'b0;
         type_q <= csc_pkg::OSC_NONE;
         st_q   <= csc_pkg::ST_RUN;
      end else begin
         mr_q   <= mr_d;
         rg_q   <= rg_d;
         tset_q <= tset_d;
         type_q <= type_d;
         st_q   <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs, computed from the next state
   logic force_d, run_d;
   logic div_tick;

   always_comb begin
      force_d = (st_d == csc_pkg::ST_STBY)  // see (R8)
         || mr_d[csc_pkg::MR_STOP] || !tset_d;  // see (R8) (R9)
      run_d = (st_d != csc_pkg::ST_STBY);
   end

   csc_div #(.CW(3)) u_div (
      .clk   (hclk),
      .rst_n (hresetn),
      .run   (st_q != csc_pkg::ST_STBY),
      .sel   (mr_q[csc_pkg::MR_DIV_LO +: 2]),
      .tick  (div_tick)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         main_clk_force_high <= 1'b1;
         main_osc_clock      <= 1'b1;
         main_osc_en         <= 1'b0;
         main_osc_type       <= 2'h0;
         ring_osc_en         <= 1'b1;
         sysclk_sel_main     <= 1'b0;
         sysclk_div          <= 2'h3;
         sysclk_tick         <= 1'b0;
         standby             <= 1'b0;
      end else begin
         main_clk_force_high <= force_d;
         main_osc_clock      <= force_d | pin_s;  // see (R8) (R9)
         main_osc_en <= run_d && tset_d
                        && !mr_d[csc_pkg::MR_STOP];  // see (R5) (R12)
         main_osc_type       <= type_d;
         ring_osc_en         <= run_d && !rg_d;  // see (R15)
         sysclk_sel_main     <= !mr_d[csc_pkg::MR_SRC];  // see (R13)
         sysclk_div          <= mr_d[csc_pkg::MR_DIV_LO +: 2];
         sysclk_tick         <= div_tick && run_d;  // see (R14)
         standby             <= !run_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_lone_enter;
      (st_q == csc_pkg::ST_RUN) && is_cmd && cmd == csc_pkg::CMD_ENTER
         |=> st_q != csc_pkg::ST_STBY;
   endproperty
   a_lone_enter: assert property (p_lone_enter)  // see (R1)
      else $error("standby entered without arming");

   property p_arm_enter;
      (st_q == csc_pkg::ST_ARMED) && is_cmd && cmd == csc_pkg::CMD_ENTER
         |=> (st_q == csc_pkg::ST_STBY) ##1 standby;
   endproperty
   a_arm_enter: assert property (p_arm_enter)  // see (R1)
      else $error("arm then enter did not reach standby");

   property p_type_once;
      tset_q |=> tset_q && $stable(type_q);
   endproperty
   a_type_once: assert property (p_type_once)  // see (R3)
      else $error("oscillator type changed after first selection");

   property p_sel_only;
      is_sel |=> $stable(mr_q) && $stable(main_osc_en)
         && $stable(sysclk_sel_main);
   endproperty
   a_sel_only: assert property (p_sel_only)  // see (R4)
      else $error("type selection changed clock control");

   property p_no_type;
      !tset_q |-> mr_q[csc_pkg::MR_SRC] && mr_q[csc_pkg::MR_STOP]
         && !main_osc_en;
   endproperty
   a_no_type: assert property (p_no_type)  // see (R5)
      else $error("main clock used with no type selected");

   property p_active_runs;
      mr_q[csc_pkg::MR_SRC] ? !rg_q
         : (tset_q && !mr_q[csc_pkg::MR_STOP]);
   endproperty
   a_active_runs: assert property (p_active_runs)  // see (R6) (R7)
      else $error("system clock source is not oscillating");

   property p_force;
      (st_q == csc_pkg::ST_STBY || mr_q[csc_pkg::MR_STOP] || !tset_q)
         |-> main_clk_force_high && main_osc_clock;
   endproperty
   a_force: assert property (p_force)  // see (R8) (R9)
      else $error("main clock input not forced high");

   property p_refuse_rg;
      rg_wr && !rg_ok |=> $stable(rg_q) && $stable(mr_q);
   endproperty
   a_refuse_rg: assert property (p_refuse_rg)  // see (R16)
      else $error("refused ring stop changed configuration");

   property p_refuse_mr;
      mr_wr && !mr_ok |=> $stable(mr_q);
   endproperty
   a_refuse_mr: assert property (p_refuse_mr)  // see (R16)
      else $error("refused clock control write took effect");

   property p_div_out;
      mr_wr && mr_ok && st_q != csc_pkg::ST_STBY |=>
         sysclk_div == $past(hwdata[3:2]) && mr_q == $past(hwdata[3:0]);
   endproperty
   a_div_out: assert property (p_div_out)  // see (R14)
      else $error("divider bits not taken from accepted write");
endmodule : csc_top
`default_nettype wire

/* tb/csc_top_bench.sv */
// self-checking bench of the clock source and standby control block
`default_nettype none
module csc_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        main_clock_input_pin = 1'b0;
   logic        wake_req = 1'b0;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        main_osc_clock;
   logic        main_clk_force_high;
   logic        main_osc_en;
   logic [1:0]  main_osc_type;
   logic        ring_osc_en;
   logic        sysclk_sel_main;
   logic [1:0]  sysclk_div;
   logic        sysclk_tick;
   logic        standby;
   // reference model state
   logic [3:0]  mr_m = 4'hF;
   logic        rg_m = 1'b0;
   logic [1:0]  ty_m = 2'h0;
   logic        arm_m = 1'b0;
   logic        sb_m = 1'b0;
   int          fails = 0;
   int          comparisons = 0;
   int          p;
   logic [2:0]  pin_h = 3'h0;

   assign hready = hreadyout;

   csc_top dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
      .hwdata, .hrdata, .hreadyout, .hresp, .main_clock_input_pin,
      .wake_req, .main_osc_clock, .main_clk_force_high, .main_osc_en,
      .main_osc_type, .ring_osc_en, .sysclk_sel_main, .sysclk_div,
      .sysclk_tick, .standby
   );

   always #5 hclk = ~hclk;

   // noisy pin; pin_h mirrors the three-flop delay in front of the output
   always @(posedge hclk) begin
      main_clock_input_pin <= 1'($urandom);
      pin_h <= {pin_h[1:0], main_clock_input_pin};
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   task automatic give_up(string what);
      fails++;
      $display("unexpected at %0t: %s timed out", $time, what);
      tally_and_finish();
   endtask : give_up

   task automatic chk_val(logic [31:0] got, logic [31:0] exp, string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h", $time, what, got);
      end
   endtask : chk_val

   function automatic logic fh();
      return sb_m || mr_m[1] || ty_m == 2'h0;
   endfunction : fh

   function automatic logic [31:0] rexp(logic [31:0] a);
      logic [2:0] st;
      st = sb_m ? 3'b100 : (arm_m ? 3'b010 : 3'b001);
      case (a[3:2])
         2'h1: return {28'h0, mr_m};
         2'h2: return {31'h0, rg_m};
         2'h3: return {25'h0, st, ty_m, ty_m != 2'h0, !fh()};
         default: return 32'h0;
      endcase
   endfunction : rexp

   // a source may only be chosen if running, the active one never stopped
   function automatic logic mr_ok(logic [3:0] n);
      if (!n[0])
         return ty_m != 2'h0 && !mr_m[1] && !n[1];
      return !rg_m && !(n[1] && !mr_m[0]) && (ty_m != 2'h0 || n[1]);
   endfunction : mr_ok

   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50)
            give_up("bus wait");
         @(posedge hclk);
      end
   endtask : wait_rdy

   // one transfer; reads compared with the model, then model advanced
   task automatic xfer(logic w, logic [31:0] a, logic [31:0] wd);
      logic [31:0] e;
      logic [2:0]  c;
      e = rexp(a);
      c = wd[2:0];
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      chk_val(hresp, 1'b0, "response");
      if (!w)
         chk_val(hrdata, e, "read data");
      if (w && a[3:2] == 2'h1 && mr_ok(wd[3:0]))
         mr_m = wd[3:0];
      if (w && a[3:2] == 2'h2 && !(wd[0] && mr_m[0]))
         rg_m = wd[0];
      if (w && a[3:2] == 2'h0) begin
         if (c >= csc_pkg::CMD_CER && c <= csc_pkg::CMD_XTL && ty_m == 2'h0)
            ty_m = c[1:0];
         if (c == csc_pkg::CMD_ENTER && arm_m) begin
            sb_m = 1'b1;
            mr_m = 4'hF;
            rg_m = 1'b0;
         end
      end
      arm_m = w && a[3:2] == 2'h0 && c == csc_pkg::CMD_ARM;
      #1;
   endtask : xfer

   task automatic cmd(logic [2:0] c);
      logic [31:0] r;
      r = $urandom;
      r[2:0] = c;
      xfer(1'b1, 32'h0, r);
   endtask : cmd

   task automatic chk_state;
      chk_val(main_clk_force_high, fh(), "force high");
      chk_val(main_osc_clock, fh() | pin_h[2], "main clock level");
      chk_val(main_osc_en, !fh(), "main enable");
      chk_val(main_osc_type, ty_m, "osc type");
      chk_val(ring_osc_en, !rg_m && !sb_m, "ring enable");
      chk_val(sysclk_sel_main, !mr_m[0], "source");
      chk_val(sysclk_div, mr_m[3:2], "divide");
      chk_val(standby, sb_m, "standby");
   endtask : chk_state

   // cycles between two ticks
   task automatic period(output int q);
      int n;
      n = 0;
      do begin @(posedge hclk); #1; n++; end
      while (sysclk_tick !== 1'b1 && n < 20);
      if (sysclk_tick !== 1'b1)
         give_up("first tick");
      q = 0;
      do begin @(posedge hclk); #1; q++; end
      while (sysclk_tick !== 1'b1 && q < 20);
      if (sysclk_tick !== 1'b1)
         give_up("second tick");
   endtask : period

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(90));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk_state();
      xfer(1'b0, 32'h4, 32'h0);
      xfer(1'b0, 32'h8, 32'h0);
      xfer(1'b0, 32'hC, 32'h0);
      $display("test 1 done");
      xfer(1'b1, 32'h4, 32'h0);
      xfer(1'b1, 32'h4, 32'h1);
      cmd(csc_pkg::CMD_IDIS);
      cmd(csc_pkg::CMD_CER);
      chk_state();
      cmd(csc_pkg::CMD_RC);
      cmd(csc_pkg::CMD_XTL);
      chk_state();
      $display("test 2 done");
      xfer(1'b1, 32'h4, 32'h5);
      chk_state();
      xfer(1'b1, 32'h4, 32'h4);
      chk_state();
      xfer(1'b1, 32'h4, 32'h6);
      xfer(1'b0, 32'h4, 32'h0);
      xfer(1'b1, 32'h8, 32'h1);
      chk_state();
      xfer(1'b1, 32'h4, 32'h5);
      xfer(1'b0, 32'h4, 32'h0);
      xfer(1'b1, 32'h8, 32'h0);
      xfer(1'b1, 32'h4, 32'h1);
      xfer(1'b1, 32'h8, 32'h1);
      chk_state();
      xfer(1'b1, 32'h4, 32'h7);
      chk_state();
      $display("test 3 done");
      for (int d = 0; d < 4; d++) begin
         xfer(1'b1, 32'h4, 32'(d * 4 + 1));
         period(p);
         chk_val(p, 32'(1 << d), "tick period");
      end
      $display("test 4 done");
      xfer(1'b1, 32'h8, 32'h0);
      cmd(csc_pkg::CMD_ENTER);
      chk_state();
      cmd(csc_pkg::CMD_ARM);
      xfer(1'b0, 32'hC, 32'h0);
      xfer(1'b0, 32'h10, 32'h0);
      cmd(csc_pkg::CMD_ENTER);
      chk_state();
      cmd(csc_pkg::CMD_IDIS);
      cmd(csc_pkg::CMD_ARM);
      cmd(csc_pkg::CMD_ENTER);
      chk_state();
      p = 0;
      repeat (8) begin
         @(posedge hclk);
         #1;
         if (sysclk_tick !== 1'b0)
            p++;
      end
      chk_val(p, 32'h0, "tick in standby");
      @(posedge hclk);
      wake_req <= 1'b1;
      p = 0;
      do begin @(posedge hclk); #1; p++; end
      while (standby !== 1'b0 && p < 20);
      if (standby !== 1'b0)
         give_up("wake");
      @(posedge hclk);
      wake_req <= 1'b0;
      #1;
      sb_m = 1'b0;
      chk_state();
      xfer(1'b0, 32'h4, 32'h0);
      $display("test 5 done");
      tally_and_finish();
   end
endmodule : csc_top_bench
`default_nettype wire
